// File: logic/adcdv_pkg.sv
// Purpose: shared constants for the converter clocking and data-valid block
// Assumes: system clock of 125 MHz; all times held in picoseconds
// Notes:   counts derived from times round up for least times
package adcdv_pkg;

  localparam int unsigned SYS_CLK_PERIOD_PS = 8000;
  localparam int unsigned SAMPLE_W          = 14;
  localparam int unsigned WORD_W            = SAMPLE_W + 1;
  localparam int unsigned PIPE_LATENCY      = 8;

  localparam int unsigned STROBE_DELAY_PS  = 5200;
  localparam int unsigned STROBE_DELAY_CYC =
    (STROBE_DELAY_PS + SYS_CLK_PERIOD_PS - 1) / SYS_CLK_PERIOD_PS;

  // fixed low phase of the strobe while the equaliser runs
  localparam int unsigned STROBE_LOW_PS  = 40000;
  localparam int unsigned STROBE_LOW_CYC =
    (STROBE_LOW_PS + SYS_CLK_PERIOD_PS - 1) / SYS_CLK_PERIOD_PS;

  localparam int unsigned LOCK_EDGES    = 100;
  localparam int unsigned PERIOD_TOL    = 2;
  localparam int unsigned DUTY_MIN_PCT  = 35;
  localparam int unsigned DUTY_MAX_PCT  = 65;
  localparam int unsigned CNT_W         = 16;

  localparam logic [SAMPLE_W-1:0] OFFSET_FLIP = 14'h2000;

  // register map (byte addresses)
  localparam int unsigned ADDR_W    = 4;
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_MASK   = 4'h4;
  localparam logic [3:0] REG_STATE  = 4'h8;

  // status and mask layout
  localparam int unsigned EVT_W         = 4;
  localparam int unsigned EVT_LOCKED    = 0;
  localparam int unsigned EVT_LOCK_LOST = 1;
  localparam int unsigned EVT_OVERRANGE = 2;
  localparam int unsigned EVT_DUTY_BAD  = 3;
  localparam logic [EVT_W-1:0] MASK_RESET = 4'h0;

  // state register layout
  localparam int unsigned ST_LOCKED = 0;
  localparam int unsigned ST_PDOWN  = 1;
  localparam int unsigned ST_DCE    = 2;
  localparam int unsigned ST_DIFF   = 3;
  localparam int unsigned ST_GRAY   = 4;

endpackage : adcdv_pkg

// File: logic/adcdv_sync.sv
// Purpose: two-flop synchroniser for a group of pin levels
// Assumes: each bit is an independent level
// Notes:   only the second stage is visible outside
module adcdv_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         i_clock,
  input  wire logic         i_reset,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } adcdv_sync_t;

  adcdv_sync_t s_q;
  adcdv_sync_t s_d;

  always_comb begin
    s_d.meta   = i_async;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_sync = s_q.stable;

endmodule : adcdv_sync

// File: logic/adcdv_delay.sv
// Purpose: fixed delay of a small group of signals by whole clock cycles
// Assumes: DEPTH of at least one
// Notes:   plain shift register, no reset value beyond zero
module adcdv_delay #(
  parameter int unsigned W     = 1,
  parameter int unsigned DEPTH = 1
) (
  input  wire logic         i_clock,
  input  wire logic         i_reset,
  input  wire logic [W-1:0] i_data,
  output logic      [W-1:0] o_data
);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] tap;
  } adcdv_delay_t;

  adcdv_delay_t s_q;
  adcdv_delay_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.tap[0] = i_data;
    for (int i = 1; i < DEPTH; i++) begin
      s_d.tap[i] = s_q.tap[i-1];
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_data = s_q.tap[DEPTH-1];

endmodule : adcdv_delay

// File: logic/adcdv_top.sv
// Purpose: clock select, duty equaliser, pipeline latency and data-valid strobe
// Assumes: conversion clock pins are sampled by the 125 MHz system clock
// Notes:   the quantizer result arrives as a two's-complement code on pins
//
// Chosen here: the strobed register port and the address map.
module adcdv_top
  import adcdv_pkg::*;
(
  input  wire logic                i_clock,
  input  wire logic                i_reset,
  input  wire logic                i_clock_in_pos,
  input  wire logic                i_clock_in_neg,
  input  wire logic                i_clock_type_select,
  input  wire logic                i_duty_equalizer_enable,
  input  wire logic                i_power_down_in,
  input  wire logic                i_format_select,
  input  wire logic [SAMPLE_W-1:0] i_analog_code,
  input  wire logic                i_analog_over_range,
  input  wire logic [ADDR_W-1:0]   i_addr,
  input  wire logic [31:0]         i_wdata,
  input  wire logic                i_wr,
  input  wire logic                i_rd,
  output logic      [31:0]         o_rdata,
  output logic      [SAMPLE_W-1:0] o_sample_bus,
  output logic                     o_sample_bus_oe,
  output logic                     o_over_range_flag,
  output logic                     o_data_valid_strobe,
  output logic                     o_data_valid_strobe_oe,
  output logic                     o_clock_inputs_hiz,
  output logic                     o_dll_locked,
  output logic                     o_irq
);

  localparam int unsigned PIN_W = 7 + SAMPLE_W;
  localparam logic [CNT_W-1:0] CNT_MAX = '1;
  localparam logic [6:0] LOCK_TARGET = 7'(LOCK_EDGES);
  localparam logic [3:0] LOW_TARGET  = 4'(STROBE_LOW_CYC);

  typedef struct packed {
    logic                            conv_prev;
    logic [PIPE_LATENCY-1:0][WORD_W-1:0] pipe;
    logic [WORD_W-1:0]               staged;
    logic [SAMPLE_W-1:0]             bus;
    logic                            ovr;
    logic                            bus_oe;
    logic                            data_valid_strobe;
    logic                            dav_oe;
    logic [3:0]                      low_cnt;
    logic                            hiz;
    logic [CNT_W-1:0]                per_cnt;
    logic [CNT_W-1:0]                high_cnt;
    logic [CNT_W-1:0]                last_per;
    logic [6:0]                      lock_cnt;
    logic                            locked;
    logic [EVT_W-1:0]                status;
    logic [EVT_W-1:0]                mask;
    logic [31:0]                     rdata;
    logic                            irq;
  } adcdv_state_t;

  adcdv_state_t s_q;
  adcdv_state_t s_d;

  // offset binary then reflected code
  function automatic logic [SAMPLE_W-1:0] to_gray(input logic [SAMPLE_W-1:0] code);
    logic [SAMPLE_W-1:0] ob;
    ob = code ^ OFFSET_FLIP;
    return ob ^ (ob >> 1);
  endfunction : to_gray

  logic [PIN_W-1:0] pins_sync;
  logic             clock_in_pos_s;
  logic             clock_in_neg_s;
  logic             diff_s;
  logic             dce_s;
  logic             pd_s;
  logic             gray_s;
  logic             ovr_s;
  logic [SAMPLE_W-1:0] code_s;
  logic             conv_clk;
  logic             conv_fall;
  logic             conv_rise;
  logic [1:0]       dly_out;
  logic             dly_clk;
  logic             dly_fall;

  adcdv_sync #(
    .W (PIN_W)
  ) u_sync (
    .i_clock (i_clock),
    .i_reset (i_reset),
    .i_async ({i_clock_in_pos, i_clock_in_neg, i_clock_type_select,
               i_duty_equalizer_enable, i_power_down_in, i_format_select,
               i_analog_over_range, i_analog_code}),
    .o_sync  (pins_sync)
  );

  assign {clock_in_pos_s, clock_in_neg_s, diff_s, dce_s, pd_s, gray_s, ovr_s, code_s} = pins_sync;

  // the negative pin only counts when the pair is driven; grounded it is ignored
  assign conv_clk  = diff_s ? (clock_in_pos_s & ~clock_in_neg_s) : clock_in_pos_s;
  assign conv_fall = s_q.conv_prev & ~conv_clk;
  assign conv_rise = ~s_q.conv_prev & conv_clk;

  adcdv_delay #(
    .W     (2),
    .DEPTH (STROBE_DELAY_CYC)
  ) u_delay (
    .i_clock (i_clock),
    .i_reset (i_reset),
    .i_data  ({conv_clk, conv_fall & ~pd_s}),
    .o_data  (dly_out)
  );

  assign {dly_clk, dly_fall} = dly_out;

  always_comb begin
    logic [EVT_W-1:0] events;
    logic [EVT_W-1:0] clr;
    logic [CNT_W-1:0] diff;
    logic [31:0]      hi_scaled;
    logic [31:0]      lo_bound;
    logic [31:0]      hi_bound;
    events    = '0;
    clr       = '0;
    diff      = '0;
    hi_scaled = '0;
    lo_bound  = '0;
    hi_bound  = '0;
    s_d       = s_q;

    s_d.conv_prev = conv_clk;

    // power-down state and pin releases
    s_d.hiz    = pd_s;
    s_d.dav_oe = ~pd_s;
    s_d.bus_oe = ~pd_s;

    // clock period and high-time measurement for the loop
    if (conv_fall) begin
      s_d.per_cnt = '0;
    end else if (s_q.per_cnt != CNT_MAX) begin
      s_d.per_cnt = s_q.per_cnt + 1'b1;
    end
    if (conv_rise) begin
      s_d.high_cnt = '0;
    end else if (conv_clk && s_q.high_cnt != CNT_MAX) begin
      s_d.high_cnt = s_q.high_cnt + 1'b1;
    end

    if (pd_s) begin
      // the loop loses its reference while the clock pins are released
      s_d.lock_cnt = '0;
      s_d.locked   = 1'b0;
    end else if (conv_fall) begin
      s_d.last_per = s_q.per_cnt;
      diff = (s_q.per_cnt > s_q.last_per) ? (s_q.per_cnt - s_q.last_per)
                                          : (s_q.last_per - s_q.per_cnt);
      if (diff > CNT_W'(PERIOD_TOL)) begin
        // frequency moved: start acquisition again
        s_d.lock_cnt = '0;
        s_d.locked   = 1'b0;
        events[EVT_LOCK_LOST] = s_q.locked;
      end else if (s_q.lock_cnt != LOCK_TARGET) begin
        s_d.lock_cnt = s_q.lock_cnt + 1'b1;
        if (s_q.lock_cnt == LOCK_TARGET - 7'h01) begin
          s_d.locked = 1'b1;
          events[EVT_LOCKED] = 1'b1;
        end
      end
      // duty window check only matters while the equaliser corrects it
      hi_scaled = 32'(s_q.high_cnt) * 32'd100;
      lo_bound  = 32'(s_q.per_cnt) * 32'(DUTY_MIN_PCT);
      hi_bound  = 32'(s_q.per_cnt) * 32'(DUTY_MAX_PCT);
      if (dce_s && s_q.locked && (hi_scaled < lo_bound || hi_scaled > hi_bound)) begin
        events[EVT_DUTY_BAD] = 1'b1;
      end
    end

    // pipeline advances on each conversion clock fall outside power-down
    if (conv_fall && !pd_s) begin
      s_d.staged  = s_q.pipe[PIPE_LATENCY-1];
      s_d.pipe[0] = {ovr_s, code_s};
      for (int i = 1; i < PIPE_LATENCY; i++) begin
        s_d.pipe[i] = s_q.pipe[i-1];
      end
    end

    // word and flag change together, on the strobe fall
    if (dly_fall) begin
      s_d.bus = gray_s ? to_gray(s_q.staged[SAMPLE_W-1:0])
                       : s_q.staged[SAMPLE_W-1:0];
      s_d.ovr = s_q.staged[WORD_W-1];
      events[EVT_OVERRANGE] = s_q.staged[WORD_W-1];
    end

    // strobe waveform
    if (pd_s) begin
      s_d.data_valid_strobe     = 1'b0;
      s_d.low_cnt = '0;
    end else if (!dce_s) begin
      s_d.data_valid_strobe     = dly_clk;
      s_d.low_cnt = '0;
    end else if (dly_fall) begin
      // width set by a counter, so a skewed input duty does not reach the pin
      s_d.data_valid_strobe     = 1'b0;
      s_d.low_cnt = LOW_TARGET;
    end else if (s_q.low_cnt != 4'h0) begin
      s_d.low_cnt = s_q.low_cnt - 4'h1;
      s_d.data_valid_strobe     = (s_q.low_cnt == 4'h1);
    end else begin
      s_d.data_valid_strobe = 1'b1;
    end

    // register port
    if (i_wr && i_addr == REG_STATUS) begin
      clr = i_wdata[EVT_W-1:0];
    end
    if (i_wr && i_addr == REG_MASK) begin
      s_d.mask = i_wdata[EVT_W-1:0];
    end
    // a new event wins over a clear in the same cycle
    s_d.status = (s_q.status & ~clr) | events;
    s_d.irq    = |(s_d.status & s_d.mask);

    s_d.rdata = '0;
    if (i_rd) begin
      case (i_addr)
        REG_STATUS: s_d.rdata = 32'(s_q.status);
        REG_MASK:   s_d.rdata = 32'(s_q.mask);
        REG_STATE: begin
          s_d.rdata[ST_LOCKED] = s_q.locked;
          s_d.rdata[ST_PDOWN]  = pd_s;
          s_d.rdata[ST_DCE]    = dce_s;
          s_d.rdata[ST_DIFF]   = diff_s;
          s_d.rdata[ST_GRAY]   = gray_s;
        end
        default: s_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      s_q      <= '0;
      s_q.mask <= MASK_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_rdata                = s_q.rdata;
  assign o_sample_bus           = s_q.bus;
  assign o_sample_bus_oe        = s_q.bus_oe;
  assign o_over_range_flag      = s_q.ovr;
  assign o_data_valid_strobe    = s_q.data_valid_strobe;
  assign o_data_valid_strobe_oe = s_q.dav_oe;
  assign o_clock_inputs_hiz     = s_q.hiz;
  assign o_dll_locked           = s_q.locked;
  assign o_irq                  = s_q.irq;

endmodule : adcdv_top

// File: verification/adcdv_monitor.sv
// Purpose: port checks for the converter clocking and data-valid block
// Assumes: conversion clock period well above 6 system cycles
// Notes:   pins pass a two-flop sync, so checks allow for its delay
module adcdv_monitor
  import adcdv_pkg::*;
(
  input wire logic                i_clock,
  input wire logic                i_reset,
  input wire logic                i_clock_in_pos,
  input wire logic                i_clock_type_select,
  input wire logic                i_duty_equalizer_enable,
  input wire logic                i_power_down_in,
  input wire logic [SAMPLE_W-1:0] o_sample_bus,
  input wire logic                o_over_range_flag,
  input wire logic                o_data_valid_strobe,
  input wire logic                o_data_valid_strobe_oe,
  input wire logic                o_clock_inputs_hiz,
  input wire logic                o_dll_locked
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);
  logic [CNT_W-1:0] run_q;
  logic [7:0]       calm_q;
  logic [2:0]       mode_q;
  wire  [2:0]       mode = {i_duty_equalizer_enable, i_power_down_in, i_clock_type_select};
  // a mode change may leave one odd strobe phase, so waveform checks wait for calm
  always_ff @(posedge i_clock) begin
    mode_q <= mode;
    if (i_reset || i_power_down_in) run_q <= '0;
    else if (run_q != '1) run_q <= run_q + 1'b1;
    if (i_reset || mode_q != mode) calm_q <= '0;
    else if (calm_q != 8'hFF) calm_q <= calm_q + 8'h01;
  end
  sequence s_asleep; (i_power_down_in && !i_reset) [*4]; endsequence
  sequence s_awake; (!i_power_down_in && !i_reset) [*4]; endsequence
  sequence s_low_phase; !o_data_valid_strobe [*5] ##1 o_data_valid_strobe; endsequence
  property p_strobe_hiz; s_asleep |-> !o_data_valid_strobe_oe; endproperty
  a_strobe_hiz: assert property (p_strobe_hiz) else $error("strobe driven asleep");
  property p_pins_hiz; s_asleep |-> o_clock_inputs_hiz; endproperty
  a_pins_hiz: assert property (p_pins_hiz) else $error("clock pins not released");
  property p_awake; s_awake |-> o_data_valid_strobe_oe && !o_clock_inputs_hiz; endproperty
  a_awake: assert property (p_awake) else $error("not awake with pin low");
  property p_bus_step;
    o_data_valid_strobe_oe && $past(o_data_valid_strobe_oe) && $changed(o_sample_bus)
      |-> $fell(o_data_valid_strobe);
  endproperty
  a_bus_step: assert property (p_bus_step) else $error("bus moved off strobe fall");
  property p_flag_step;
    o_data_valid_strobe_oe && $past(o_data_valid_strobe_oe) && $changed(o_over_range_flag)
      |-> $fell(o_data_valid_strobe);
  endproperty
  a_flag_step: assert property (p_flag_step) else $error("flag moved off strobe fall");
  property p_copy;
    calm_q >= 8'd40 && mode == 3'b000 |-> o_data_valid_strobe == $past(i_clock_in_pos, 3)
      || o_data_valid_strobe == $past(i_clock_in_pos, 4)
      || o_data_valid_strobe == $past(i_clock_in_pos, 5);
  endproperty
  a_copy: assert property (p_copy) else $error("strobe not a copy of clock");
  property p_fixed_low;
    calm_q >= 8'd40 && mode[2:1] == 2'b10 && $fell(o_data_valid_strobe) |-> s_low_phase;
  endproperty
  a_fixed_low: assert property (p_fixed_low) else $error("strobe width not fixed");
  property p_lock_wait; $rose(o_dll_locked) |-> run_q >= 16'd200; endproperty
  a_lock_wait: assert property (p_lock_wait) else $error("lock came too soon");
endmodule : adcdv_monitor

bind adcdv_top adcdv_monitor u_monitor (
  .i_clock(i_clock), .i_reset(i_reset), .i_clock_in_pos(i_clock_in_pos),
  .i_clock_type_select(i_clock_type_select), .i_power_down_in(i_power_down_in),
  .i_duty_equalizer_enable(i_duty_equalizer_enable), .o_sample_bus(o_sample_bus),
  .o_over_range_flag(o_over_range_flag), .o_data_valid_strobe(o_data_valid_strobe),
  .o_data_valid_strobe_oe(o_data_valid_strobe_oe), .o_dll_locked(o_dll_locked),
  .o_clock_inputs_hiz(o_clock_inputs_hiz)
);

// File: verification/adcdv_backend.sv
// Purpose: back-end capture logic clocked by the data-valid strobe
// Assumes: strobe and bus are only meaningful while driven
// Notes:   counts each word so the bench can compare it
module adcdv_backend
  import adcdv_pkg::*;
(
  input  wire logic                i_data_valid_strobe,
  input  wire logic                i_data_valid_strobe_oe,
  input  wire logic [SAMPLE_W-1:0] i_sample_bus,
  input  wire logic                i_sample_bus_oe,
  input  wire logic                i_over_range_flag,
  output logic      [WORD_W-1:0]   o_word,
  output int                       o_count
);
  timeunit 1ns;
  timeprecision 100ps;
  initial o_count = 0;
  always @(posedge i_data_valid_strobe) begin
    // a released bus is ignored, not latched
    if (i_data_valid_strobe_oe && i_sample_bus_oe) begin
      o_word  <= {i_over_range_flag, i_sample_bus};
      o_count <= o_count + 1;
    end
  end
endmodule : adcdv_backend

// File: verification/adcdv_top_tb.sv
// Purpose: self-checking bench for the converter clocking and data-valid block
// Assumes: conversion clock from its own loop, unrelated to i_clock
// Notes:   falls seen in power-down are not counted, as the pipe is frozen
module adcdv_top_tb
  import adcdv_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic                i_clock, i_reset, pos, neg, typ, dce, pd, fmt, aor, wr, rd, chk_on;
  logic                bus_oe, orf, dv, dv_oe, hiz, locked, irq;
  logic [SAMPLE_W-1:0] code, bus;
  logic [ADDR_W-1:0]   addr;
  logic [31:0]         wdata, rdata, r;
  logic [WORD_W-1:0]   be_word;
  logic [WORD_W-1:0]   hist [0:4095];
  int                  be_count, nf, cycles, fail_count, n_checks;
  real                 hi, lo;

  adcdv_top dut (.i_clock(i_clock), .i_reset(i_reset), .i_clock_in_pos(pos),
    .i_clock_in_neg(neg), .i_clock_type_select(typ), .i_duty_equalizer_enable(dce),
    .i_power_down_in(pd), .i_format_select(fmt), .i_analog_code(code),
    .i_analog_over_range(aor), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .o_sample_bus(bus), .o_sample_bus_oe(bus_oe),
    .o_over_range_flag(orf), .o_data_valid_strobe(dv), .o_data_valid_strobe_oe(dv_oe),
    .o_clock_inputs_hiz(hiz), .o_dll_locked(locked), .o_irq(irq));
  adcdv_backend u_backend (.i_data_valid_strobe(dv), .i_data_valid_strobe_oe(dv_oe),
    .i_sample_bus(bus), .i_sample_bus_oe(bus_oe), .i_over_range_flag(orf),
    .o_word(be_word), .o_count(be_count));

  initial begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end
  // code moves on the rise so that it is steady at the sampling fall
  initial begin
    pos  = 1'b0;
    neg  = 1'b0;
    aor  = 1'b0;
    nf   = 0;
    hi   = 62.5;
    lo   = 62.5;
    code = 14'h1FF0;
    forever begin
      #(hi) pos = 1'b1;
      neg = 1'b0;
      code = code + 14'h0155;
      aor = code[3];
      #(lo) pos = 1'b0;
      neg = typ;
      if (!pd) begin
        hist[nf] = {aor, code};
        nf++;
      end
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clock);
    {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge i_clock);
    wr <= 1'b0;
  endtask : reg_wr
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge i_clock);
    {addr, rd} <= {a, 1'b1};
    @(posedge i_clock);
    rd <= 1'b0;
    @(posedge i_clock);
    r = rdata;
    check("register", r & m, e);
  endtask : rd_chk
  task automatic falls(input int n);
    repeat (n) @(negedge pos);
  endtask : falls
  // wait until this period's strobe rise has captured, so a pin change hits the next word
  task automatic mid_high;
    @(posedge pos);
    repeat (5) @(posedge i_clock);
  endtask : mid_high
  function automatic logic [WORD_W-1:0] want(input logic [WORD_W-1:0] s, input logic g);
    logic [SAMPLE_W-1:0] b;
    b = s[SAMPLE_W-1:0] ^ 14'h2000;
    return {s[SAMPLE_W], g ? (b ^ (b >> 1)) : s[SAMPLE_W-1:0]};
  endfunction : want

  always @(be_count) begin
    if (chk_on) check("captured word", be_word, want(hist[nf-9], fmt));
  end
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      final_report();
    end
  end

  initial begin
    {i_reset, typ, dce, pd, fmt, wr, rd, chk_on, addr, wdata} = {8'h80, 36'h0};
    {fail_count, n_checks, cycles} = 96'h0;
    repeat (6) @(posedge i_clock);
    i_reset <= 1'b0;
    rd_chk(REG_MASK, 32'h0, 32'hFFFFFFFF);
    reg_wr(4'hC, 32'hFFFFFFFF);
    rd_chk(4'hC, 32'h0, 32'hFFFFFFFF);
    reg_wr(REG_MASK, 32'h1);
    falls(12);
    chk_on = 1'b1;
    falls(78);
    check("early lock", locked, 1'b0);
    check("early irq", irq, 1'b0);
    falls(20);
    check("lock", locked, 1'b1);
    check("irq", irq, 1'b1);
    rd_chk(REG_STATE, 32'h1, 32'h1F);
    reg_wr(REG_STATUS, 32'h1);
    @(posedge i_clock);
    check("irq cleared", irq, 1'b0);
    mid_high();
    fmt <= 1'b1;
    falls(4);
    rd_chk(REG_STATE, 32'h11, 32'h1F);
    mid_high();
    {fmt, typ} <= 2'b01;
    falls(6);
    rd_chk(REG_STATE, 32'h9, 32'h1F);
    mid_high();
    dce <= 1'b1;
    hi = 43.75;
    lo = 81.25;
    falls(10);
    rd_chk(REG_STATE, 32'hD, 32'h1F);
    hi = 81.25;
    lo = 43.75;
    falls(10);
    hi = 25.0;
    lo = 100.0;
    falls(6);
    rd_chk(REG_STATUS, 32'h8, 32'h8);
    hi = 62.5;
    lo = 62.5;
    falls(2);
    mid_high();
    pd <= 1'b1;
    repeat (5) @(posedge i_clock);
    check("strobe oe", dv_oe, 1'b0);
    check("bus oe", bus_oe, 1'b0);
    check("clock pins", hiz, 1'b1);
    falls(3);
    rd_chk(REG_STATE, 32'hE, 32'h1F);
    mid_high();
    pd <= 1'b0;
    falls(12);
    check("strobe oe back", dv_oe, 1'b1);
    check("clock pins back", hiz, 1'b0);
    falls(110);
    reg_wr(REG_STATUS, 32'hF);
    chk_on = 1'b0;
    hi = 100.0;
    lo = 100.0;
    falls(4);
    check("lock after step", locked, 1'b0);
    rd_chk(REG_STATUS, 32'h2, 32'h2);
    check("masked irq", irq, 1'b0);
    final_report();
  end
endmodule : adcdv_top_tb
